// *** dv/bridge_secondary_bus_power_test.sv ***
// Self-checking bench for the secondary bus power sequencer.
// Assumes bsp_pkg and bsp_top; restore hold shortened to 8 cycles.
module bridge_secondary_bus_power_test;
	timeunit 1ns;
	timeprecision 1ps;
	import bsp_pkg::*;

	// =====
	// Signals
	localparam int HOLD = 8;
	logic clk, sys_rst, power_good, m66en, b2_sel_strap, ctrl_en_strap;
	logic ps_wr, seg_fast;
	logic [1:0] ps_wr_data, power_state_field, bus_state;
	logic off_vs_stopclock_select, bus_power_clock_ctrl_enable;
	logic deep_sleep_support_flag, sec_bus_quiet, seg_66mhz, sec_clk;
	logic sec_clk_stopped, sec_clk_run, sec_vcc_en, sec_rst_n;
	logic [7:0] rises;
	int n_errors = 0;
	int checks_done = 0;

	bsp_top #(.RST_HOLD(HOLD)) u_dut (
		.clk, .sys_rst, .power_good, .m66en, .b2_sel_strap,
		.ctrl_en_strap, .ps_wr, .ps_wr_data, .power_state_field,
		.off_vs_stopclock_select, .bus_power_clock_ctrl_enable,
		.deep_sleep_support_flag, .bus_state, .sec_bus_quiet,
		.seg_66mhz, .sec_clk, .sec_clk_stopped, .sec_clk_run,
		.sec_vcc_en, .sec_rst_n
	);

	bsp_seg_model u_seg (
		.clk, .sec_clk, .sec_vcc_en, .seg_fast, .m66en, .rises
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// =====
	// Tasks
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Straps and segment speed only move under reset, as the pins would
	task automatic do_reset(input logic sel, en, fast);
		sys_rst = 1'b1;
		b2_sel_strap = sel;
		ctrl_en_strap = en;
		seg_fast = fast;
		cyc(8);
		sys_rst = 1'b0;
		cyc(1);
	endtask

	task automatic wr(input logic [1:0] d);
		ps_wr = 1'b1;
		ps_wr_data = d;
		cyc(1);
		ps_wr = 1'b0;
		cyc(2);
	endtask

	// A bound that runs out ends the run
	task automatic wait_bs(input logic [1:0] e, input int n);
		for (int i = 0; i < n && bus_state !== e; i++)
			cyc(1);
		chk("bus_state", 8'(e), 8'(bus_state));
		if (bus_state !== e)
			close_out();
	endtask

	task automatic rate(input int n);
		logic [7:0] r;
		r = rises;
		cyc(16);
		chk("clock rises", 8'(n), rises - r);
	endtask

	// =====
	// Scenarios
	task automatic t_reset();
		wr(PS_D1);
		do_reset(1'b1, 1'b1, 1'b0);
		chk("bus_state", BS_B0, bus_state);
		chk("field", PS_D0, power_state_field);
		chk("vcc", 1, sec_vcc_en);
		chk("rst_n", 1, sec_rst_n);
		chk("sel ro", 1, off_vs_stopclock_select);
		chk("en ro", 1, bus_power_clock_ctrl_enable);
		cyc(6);
		chk("flag", 1, deep_sleep_support_flag);
		chk("seg66", 0, seg_66mhz);
		rate(4);
		$display("reset test done");
	endtask

	// After the B2 to B0 step no segment function is accessed
	task automatic t_map();
		logic [1:0] ps[4] = '{PS_D1, PS_D0, PS_D2, PS_D0};
		logic [1:0] bs[4] = '{BS_B1, BS_B0, BS_B2, BS_B0};
		for (int k = 0; k < 4; k++) begin
			wr(ps[k]);
			chk("field", ps[k], power_state_field);
			chk("bus_state", bs[k], bus_state);
			chk("quiet", ps[k] != PS_D0, sec_bus_quiet);
			chk("run", ps[k] != PS_D2, sec_clk_run);
			if (ps[k] == PS_D2) begin
				cyc(8);
				chk("stopped", 1, sec_clk_stopped);
				chk("sec_clk", 0, sec_clk);
				rate(0);
			end
		end
		$display("mapping test done");
	endtask

	task automatic t_d3b2();
		wr(PS_D3HOT);
		chk("bus_state", BS_B2, bus_state);
		chk("vcc", 1, sec_vcc_en);
		chk("run", 0, sec_clk_run);
		wr(PS_D1);
		chk("field", PS_D3HOT, power_state_field);
		wr(PS_D0);
		chk("bus_state", BS_B0, bus_state);
		$display("d3hot b2 test done");
	endtask

	task automatic t_d3b3();
		int n;
		do_reset(1'b0, 1'b1, 1'b0);
		chk("sel ro", 0, off_vs_stopclock_select);
		wr(PS_D3HOT);
		chk("bus_state", BS_B3, bus_state);
		chk("vcc", 0, sec_vcc_en);
		wr(PS_D0);
		cyc(1);
		chk("vcc", 1, sec_vcc_en);
		chk("rst_n", 0, sec_rst_n);
		for (n = 0; n < 40 && sec_rst_n === 1'b0; n++)
			cyc(1);
		// Two cycles of the hold have passed before the loop starts
		chk("reset length", 1, n + 2 >= HOLD && n + 2 <= HOLD + 1);
		wait_bs(BS_B0, 2);
		$display("d3hot b3 test done");
	endtask

	task automatic t_ctrl();
		do_reset(1'b0, 1'b0, 1'b0);
		chk("en ro", 0, bus_power_clock_ctrl_enable);
		wr(PS_D3HOT);
		chk("bus_state", BS_B3, bus_state);
		chk("vcc", 1, sec_vcc_en);
		wr(PS_D0);
		chk("bus_state", BS_B0, bus_state);
		$display("control disabled test done");
	endtask

	// No D2 write here: a 66 MHz segment never goes to B2
	task automatic t_66();
		do_reset(1'b1, 1'b1, 1'b1);
		cyc(6);
		chk("seg66", 1, seg_66mhz);
		chk("flag", 0, deep_sleep_support_flag);
		rate(8);
		power_good = 1'b0;
		wait_bs(BS_B3, 8);
		chk("vcc", 0, sec_vcc_en);
		wr(PS_D1);
		chk("field", PS_D0, power_state_field);
		power_good = 1'b1;
		wait_bs(BS_B0, 40);
		chk("rst_n", 1, sec_rst_n);
		rate(8);
		$display("66 MHz and power loss test done");
	endtask

	// =====
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		power_good = 1'b1;
		ps_wr = 1'b0;
		ps_wr_data = 2'h0;
		b2_sel_strap = 1'b1;
		ctrl_en_strap = 1'b1;
		seg_fast = 1'b0;
		do_reset(1'b1, 1'b1, 1'b0);
		t_reset();
		t_map();
		t_d3b2();
		t_d3b3();
		t_ctrl();
		t_66();
		close_out();
	end
endmodule

// *** dv/bsp_seg_model.sv ***
// Secondary bus segment model: clock load and M66EN pin of the segment.
// Assumes the bench moves seg_fast only while the bus reset is held.
module bsp_seg_model (
	// System clock used to sample the segment
	input wire logic clk,
	// From the bridge
	input wire logic sec_clk,
	input wire logic sec_vcc_en,
	// Segment setup from the bench
	input wire logic seg_fast,
	// To the bridge and the bench
	output logic m66en,
	output logic [7:0] rises
);
	timeunit 1ns;
	timeprecision 1ps;

	logic last = 1'b0;
	logic [7:0] n_rise = 8'h0;

	assign rises = n_rise;

	// Pin reads low while the segment has no Vcc
	assign m66en = seg_fast & sec_vcc_en;

	// Counts rising clock edges seen by the functions on the segment
	always @(posedge clk) begin
		last <= sec_clk;
		if (sec_clk && !last)
			n_rise <= n_rise + 8'h1;
	end
endmodule

// *** src/bsp_clkgen.sv ***
// Secondary bus clock divider with a glitch-free stop in the low phase.
// Assumes fast only changes while the secondary bus reset is asserted.
module bsp_clkgen
	import bsp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Control
	input wire logic run,
	input wire logic fast,
	// Secondary clock
	output logic sec_clk,
	output logic stopped
);
	logic [DIV_W-1:0] cnt;
	logic [DIV_W-1:0] half;

	always_comb begin
		half = fast ? DIV_W'(HALF_FAST) : DIV_W'(HALF_SLOW);
	end

	// ==========================================================
	// Divider: one tick per half period
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt <= '0;
		end else if (cnt == '0) begin
			cnt <= half - DIV_W'(1);
		end else begin
			cnt <= cnt - DIV_W'(1);
		end
	end

	// Finishing a high phase before stopping avoids a runt pulse
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sec_clk <= 1'b0;
		end else if (cnt == '0 && (run || sec_clk)) begin // [RQ18]
			sec_clk <= ~sec_clk;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stopped <= 1'b0;
		end else begin
			stopped <= !run && !sec_clk;
		end
	end
endmodule

// *** src/bsp_pkg.sv ***
// Constants, encodings and helpers for the secondary bus power sequencer.
// Assumes a single 50 MHz system clock shared by all bsp_ modules.
package bsp_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 50;
	// Bus reset hold after secondary Vcc comes back
	localparam int RST_HOLD_US = 100;
	localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
	localparam int CNT_W = 16;
	// Secondary clock half periods in system clocks
	localparam int HALF_FAST = 1;
	localparam int HALF_SLOW = 2;
	localparam int DIV_W = 4;

	// ==========================================================
	// Bridge power state field codes
	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D1 = 2'h1;
	localparam logic [1:0] PS_D2 = 2'h2;
	localparam logic [1:0] PS_D3HOT = 2'h3;

	// Secondary bus state codes as reported
	localparam logic [1:0] BS_B0 = 2'h0;
	localparam logic [1:0] BS_B1 = 2'h1;
	localparam logic [1:0] BS_B2 = 2'h2;
	localparam logic [1:0] BS_B3 = 2'h3;

	// Synchroniser reset value: power present, 33 MHz segment
	localparam logic [1:0] SYNC_RST = 2'h1;

	typedef enum logic [2:0] {
		ST_B0,
		ST_B1,
		ST_B2,
		ST_B3,
		ST_RESTORE
	} bsp_state_e;

	// Bus state that a bridge power state leads to
	function automatic bsp_state_e bsp_bus_target(
		input logic [1:0] ps,
		input logic sel_b2
	);
		bsp_state_e t;
		t = ST_B0;
		case (ps)
			PS_D0: t = ST_B0;
			PS_D1: t = ST_B1;
			PS_D2: t = ST_B2;
			default: t = sel_b2 ? ST_B2 : ST_B3;
		endcase
		return t;
	endfunction

	// Reported code of an internal state
	function automatic logic [1:0] bsp_bus_code(input bsp_state_e s);
		logic [1:0] c;
		c = BS_B0;
		case (s)
			ST_B0: c = BS_B0;
			ST_B1: c = BS_B1;
			ST_B2: c = BS_B2;
			default: c = BS_B3;
		endcase
		return c;
	endfunction

endpackage

// *** src/bsp_sync.sv ***
// Three-stage synchroniser for pins; output moves when stages 2 and 3 agree.
// Assumes inputs are quasi-static levels from outside the clk domain.
module bsp_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins in, filtered levels out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// Stages run through reset as well: the bus reset that follows a
	// system reset lasts one cycle, too short to wait for them after it.
	always_ff @(posedge clk) begin
		s1 <= d;
		s2 <= s1;
		s3 <= s2;
	end

	// Reset value only stands while the stages have not settled yet
	always_ff @(posedge clk) begin
		for (int i = 0; i < W; i++) begin
			if (s2[i] == s3[i]) begin
				q[i] <= s3[i];
			end else if (sys_rst) begin
				q[i] <= RST_VAL[i];
			end
		end
	end
endmodule

// *** src/bsp_top.sv ***
// Secondary bus power and clock sequencer of a bridge.
// Assumes software drives the power state port and straps stay static.
//
// Function
// RQ1 - System reset returns secondary bus to B0
// RQ2 - Power loss puts secondary bus in B3
// RQ3 - Otherwise only software writes change bus state
// RQ4 - B3 on D3hot is optional, B2 alternative
// RQ5 - Drive secondary clock or sideband run control
// RQ6 - Clock frequency changes only during bus reset
// RQ7 - 66 MHz segment reads deep sleep flag 0
// RQ8 - Software never puts such segment into B2
// RQ9 - Detect 66 MHz operation by sampling M66EN
// RQ10 - Bus state tracks programmed bridge power state
// RQ11 - In B1 assume no secondary bus traffic
// RQ12 - D0 gives B0, D1 B1, D3cold B3
// RQ13 - D2 gives B2 with secondary clock stopped
// RQ14 - D3hot stops clock; Vcc off only for B3
// RQ15 - D3hot alone maps to B2 or B3
// RQ16 - Read-only bit selects B2 or B3 for D3hot
// RQ17 - Read-only enable gives control to bridge
// RQ18 - Stopped clock in B2 is held low
// RQ19 - Vcc return asserts bus reset then idle
// RQ20 - Software waits 50 ms after B2 to B0
module bsp_top #(
	parameter int RST_HOLD = bsp_pkg::RST_HOLD_CYC,
	parameter bit CAP_66 = 1'b1,
	parameter bit STOP_OK_66 = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins
	input wire logic power_good,
	input wire logic m66en,
	// Straps for the read-only bits
	input wire logic b2_sel_strap,
	input wire logic ctrl_en_strap,
	// Software access to the power state field
	input wire logic ps_wr,
	input wire logic [1:0] ps_wr_data,
	output logic [1:0] power_state_field,
	output logic off_vs_stopclock_select,
	output logic bus_power_clock_ctrl_enable,
	output logic deep_sleep_support_flag,
	// Secondary bus status
	output logic [1:0] bus_state,
	output logic sec_bus_quiet,
	output logic seg_66mhz,
	// Secondary bus power, clock and reset
	output logic sec_clk,
	output logic sec_clk_stopped,
	output logic sec_clk_run,
	output logic sec_vcc_en,
	output logic sec_rst_n
);
	import bsp_pkg::*;

	logic [1:0] sync_q;
	logic power_ok;
	logic m66;
	logic clk_fast;
	logic [CNT_W-1:0] cnt;
	bsp_state_e fsm;
	bsp_state_e next_fsm;

	// ==========================================================
	// Pin synchronisation
	bsp_sync #(
		.W(2),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d({m66en, power_good}),
		.q(sync_q)
	);

	always_comb begin
		power_ok = sync_q[0];
		m66 = sync_q[1]; // [RQ9]
	end

	// ==========================================================
	// Read-only bits, caught while reset is held
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			off_vs_stopclock_select <= b2_sel_strap; // [RQ16] [RQ4]
			bus_power_clock_ctrl_enable <= ctrl_en_strap; // [RQ17]
		end
	end

	// Clock cannot be stopped on a 66 MHz segment unless built for it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			deep_sleep_support_flag <= 1'b1;
			seg_66mhz <= 1'b0;
		end else begin
			deep_sleep_support_flag <= !(CAP_66 && m66 && !STOP_OK_66); // [RQ7]
			seg_66mhz <= m66;
		end
	end

	// ==========================================================
	// Power state field
	// Writes are ignored while power is absent or the bus is restoring.
	// From D3hot only D0 is a legal move.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			power_state_field <= PS_D0; // [RQ1]
		end else if (!power_ok) begin
			power_state_field <= PS_D0; // [RQ2]
		end else if (ps_wr && fsm != ST_RESTORE &&
			(power_state_field != PS_D3HOT || ps_wr_data == PS_D0)) begin
			power_state_field <= ps_wr_data; // [RQ3] [RQ10]
		end
	end

	// ==========================================================
	// Secondary bus state machine
	always_comb begin
		next_fsm = fsm;
		if (!power_ok) begin
			next_fsm = ST_B3; // [RQ2]
		end else begin
			case (fsm)
				ST_RESTORE: begin
					if (cnt == '0) begin
						next_fsm = ST_B0; // [RQ19]
					end
				end
				ST_B3: begin
					if (power_state_field != PS_D3HOT) begin
						// Vcc that was really off needs a bus reset
						next_fsm = sec_vcc_en ?
							bsp_bus_target(power_state_field,
							off_vs_stopclock_select) : ST_RESTORE; // [RQ19]
					end
				end
				default: begin
					next_fsm = bsp_bus_target(power_state_field,
						off_vs_stopclock_select); // [RQ12] [RQ13] [RQ15]
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fsm <= ST_B0; // [RQ1]
		end else begin
			fsm <= next_fsm;
		end
	end

	// Bus reset hold counter after Vcc returns
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt <= '0;
		end else if (next_fsm == ST_RESTORE && fsm != ST_RESTORE) begin
			cnt <= CNT_W'(RST_HOLD - 1);
		end else if (fsm == ST_RESTORE && cnt != '0) begin
			cnt <= cnt - CNT_W'(1);
		end
	end

	// ==========================================================
	// Status outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_state <= BS_B0;
			sec_bus_quiet <= 1'b0;
		end else begin
			bus_state <= bsp_bus_code(next_fsm); // [RQ10]
			sec_bus_quiet <= next_fsm != ST_B0 &&
				next_fsm != ST_RESTORE; // [RQ11]
		end
	end

	// ==========================================================
	// Power, clock and reset actions
	// With control disabled another scheme owns Vcc and clock, so both
	// stay on; only a real supply loss turns Vcc and the clock off.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sec_vcc_en <= 1'b1;
		end else begin
			sec_vcc_en <= !(next_fsm == ST_B3 &&
				(bus_power_clock_ctrl_enable || !power_ok)); // [RQ14] [RQ17]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sec_clk_run <= 1'b1;
		end else if (!power_ok) begin
			sec_clk_run <= 1'b0; // [RQ2]
		end else begin
			sec_clk_run <= !bus_power_clock_ctrl_enable ||
				next_fsm == ST_B0 || next_fsm == ST_B1 ||
				next_fsm == ST_RESTORE; // [RQ5] [RQ13] [RQ14]
		end
	end

	// System reset is the secondary bus reset as well
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sec_rst_n <= 1'b0; // [RQ1]
		end else begin
			sec_rst_n <= !(next_fsm == ST_RESTORE || !power_ok); // [RQ19]
		end
	end

	// Frequency follows the segment speed, but only under bus reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clk_fast <= 1'b0;
		end else if (!sec_rst_n) begin
			clk_fast <= m66; // [RQ6]
		end
	end

	bsp_clkgen u_clkgen (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(sec_clk_run),
		.fast(clk_fast),
		.sec_clk(sec_clk), // [RQ5]
		.stopped(sec_clk_stopped)
	);

	// ==========================================================
	// Assertions
	property p_reset_b0;
		@(posedge clk) sys_rst |=> bus_state == BS_B0 && sec_vcc_en;
	endproperty
	a_reset_b0: assert property (p_reset_b0) // [RQ1]
		else $error("bus not in B0 after system reset");

	property p_loss_b3;
		@(posedge clk) disable iff (sys_rst)
		!power_ok |=> bus_state == BS_B3 && !sec_vcc_en && !sec_clk_run;
	endproperty
	a_loss_b3: assert property (p_loss_b3) // [RQ2]
		else $error("power loss did not give B3");

	property p_sw_only;
		@(posedge clk) disable iff (sys_rst)
		$changed(power_state_field) |-> $past(ps_wr) || $past(!power_ok);
	endproperty
	a_sw_only: assert property (p_sw_only) // [RQ3]
		else $error("power state changed without a write");

	property p_freq_in_reset;
		@(posedge clk) disable iff (sys_rst)
		$changed(clk_fast) |-> $past(!sec_rst_n);
	endproperty
	a_freq_in_reset: assert property (p_freq_in_reset) // [RQ6]
		else $error("clock rate changed outside bus reset");

	property p_flag_66;
		@(posedge clk) disable iff (sys_rst)
		CAP_66 && !STOP_OK_66 && m66 |=> !deep_sleep_support_flag;
	endproperty
	a_flag_66: assert property (p_flag_66) // [RQ7]
		else $error("deep sleep flag set on 66 MHz segment");

	property p_d1_b1;
		@(posedge clk) disable iff (sys_rst)
		power_ok && power_state_field == PS_D1 |=>
			bus_state == BS_B1 && sec_bus_quiet && sec_clk_run;
	endproperty
	a_d1_b1: assert property (p_d1_b1) // [RQ12]
		else $error("D1 did not give B1");

	property p_d2_stop;
		@(posedge clk) disable iff (sys_rst)
		power_ok && power_state_field == PS_D2 && bus_power_clock_ctrl_enable
			|=> bus_state == BS_B2 && !sec_clk_run && sec_vcc_en;
	endproperty
	a_d2_stop: assert property (p_d2_stop) // [RQ13]
		else $error("D2 did not stop the clock in B2");

	property p_d3hot;
		@(posedge clk) disable iff (sys_rst)
		power_ok && power_state_field == PS_D3HOT &&
			bus_power_clock_ctrl_enable |=> !sec_clk_run &&
			(sec_vcc_en == off_vs_stopclock_select);
	endproperty
	a_d3hot: assert property (p_d3hot) // [RQ14]
		else $error("D3hot clock or Vcc action wrong");

	property p_d3hot_map;
		@(posedge clk) disable iff (sys_rst)
		power_ok && power_state_field == PS_D3HOT |=>
			bus_state == (off_vs_stopclock_select ? BS_B2 : BS_B3);
	endproperty
	a_d3hot_map: assert property (p_d3hot_map) // [RQ15]
		else $error("D3hot mapped to wrong bus state");

	property p_ctrl_off;
		@(posedge clk) disable iff (sys_rst)
		!bus_power_clock_ctrl_enable && power_ok |=> sec_vcc_en && sec_clk_run;
	endproperty
	a_ctrl_off: assert property (p_ctrl_off) // [RQ17]
		else $error("control acted while disabled");

	property p_clk_low;
		@(posedge clk) disable iff (sys_rst)
		$fell(sec_clk_run) |-> ##[0:6] (!sec_clk && sec_clk_stopped) or
			##[0:6] sec_clk_run;
	endproperty
	a_clk_low: assert property (p_clk_low) // [RQ18]
		else $error("clock not parked low after stop");

	property p_clk_hold;
		@(posedge clk) disable iff (sys_rst)
		!sec_clk_run && !sec_clk |=> !sec_clk;
	endproperty
	a_clk_hold: assert property (p_clk_hold) // [RQ18]
		else $error("stopped clock left the low level");

	property p_vcc_reset;
		@(posedge clk) disable iff (sys_rst)
		$rose(sec_vcc_en) |-> !sec_rst_n && bus_state == BS_B3;
	endproperty
	a_vcc_reset: assert property (p_vcc_reset) // [RQ19]
		else $error("Vcc returned without bus reset");

	property p_ro_keep;
		@(posedge clk) disable iff (sys_rst)
		$stable(off_vs_stopclock_select) &&
			$stable(bus_power_clock_ctrl_enable);
	endproperty
	a_ro_keep: assert property (p_ro_keep) // [RQ16]
		else $error("read-only bit moved outside reset");

	property p_quiet;
		@(posedge clk) disable iff (sys_rst)
		bus_state == BS_B1 || bus_state == BS_B2 |-> sec_bus_quiet;
	endproperty
	a_quiet: assert property (p_quiet) // [RQ11]
		else $error("bus not marked quiet in B1 or B2");

	property p_b0_b1_on;
		@(posedge clk) disable iff (sys_rst)
		bus_state == BS_B0 || bus_state == BS_B1 |->
			sec_clk_run && sec_vcc_en;
	endproperty
	a_b0_b1_on: assert property (p_b0_b1_on) // [RQ12]
		else $error("clock or Vcc off in B0 or B1");
endmodule
